//--- common/isbc_pkg.sv
// Purpose: Constants for the banked control window of the IR serial port
// Assumes: One 8-byte window, eight banks of eight byte registers
// Notes: Field positions follow the banked register layout

package isbc_pkg;

  // ********************************************************
  // Window and bank layout
  // ********************************************************
  localparam int ISBC_AW = 3;
  localparam int ISBC_NBANK = 8;
  localparam logic [2:0] ISBC_OFF_RXTX = 3'h0;
  localparam logic [2:0] ISBC_OFF_IER = 3'h1;
  localparam logic [2:0] ISBC_OFF_EVFIFO = 3'h2;
  localparam logic [2:0] ISBC_OFF_BANKSEL = 3'h3;
  localparam logic [2:0] ISBC_OFF_MCR = 3'h4;
  localparam logic [2:0] ISBC_OFF_LSR = 3'h5;
  localparam logic [2:0] ISBC_OFF_MSR = 3'h6;
  localparam logic [2:0] ISBC_OFF_SPR = 3'h7;
  localparam logic [2:0] ISBC_BANK0 = 3'h0;
  localparam logic [2:0] ISBC_BANK1 = 3'h1;
  localparam logic [2:0] ISBC_BANK2 = 3'h2;
  localparam logic [2:0] ISBC_BANK3 = 3'h3;
  localparam logic [2:0] ISBC_BANK4 = 3'h4;
  localparam logic [2:0] ISBC_BANK5 = 3'h5;
  localparam logic [2:0] ISBC_BANK6 = 3'h6;
  localparam logic [2:0] ISBC_BANK7 = 3'h7;

  // ********************************************************
  // Bank selector encoding
  // ********************************************************
  localparam int ISBC_BKSE_BIT = 7;
  localparam logic [7:0] ISBC_BANKSEL_RST = 8'h00;
  // Selector values with bit 7 set map to banks 1..7
  localparam logic [7:0] ISBC_SEL_B2 = 8'he0;
  localparam logic [7:0] ISBC_SEL_B3 = 8'he4;
  localparam logic [7:0] ISBC_SEL_B4 = 8'he8;
  localparam logic [7:0] ISBC_SEL_B5 = 8'hec;
  localparam logic [7:0] ISBC_SEL_B6 = 8'hf0;
  localparam logic [7:0] ISBC_SEL_B7 = 8'hf4;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int ISBC_EXT_SL_BIT = 0;
  localparam int ISBC_LOCK_BIT = 7;
  localparam int ISBC_MDSL_LSB = 5;
  localparam int ISBC_DMA_EN_BIT = 2;
  localparam int ISBC_FIFO_EN_BIT = 0;
  localparam logic [7:0] ISBC_LSR_W1C_MASK = 8'h1e;
  localparam logic [7:0] ISBC_ASCR_W1C_MASK = 8'h5d;
  localparam logic [7:0] ISBC_ZERO = 8'h00;
  localparam logic [7:0] ISBC_LSR_RST = 8'h60;
  localparam logic [3:0] ISBC_MODULE_ID = 4'h5;  // Arbitrary value
  localparam logic [3:0] ISBC_REV_ID = 4'h1;     // Arbitrary value

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    ISBC_LVL_16450 = 2'b00,
    ISBC_LVL_16550 = 2'b01,
    ISBC_LVL_EXT = 2'b10
  } isbc_level_t;

  typedef enum logic [2:0] {
    ISBC_MODE_UART = 3'b000,
    ISBC_MODE_VIR = 3'b001,
    ISBC_MODE_SIR = 3'b010,
    ISBC_MODE_CRIR = 3'b011
  } isbc_mode_t;

  typedef enum logic [1:0] {
    ISBC_DMA_NONE = 2'b00,
    ISBC_DMA_ONE = 2'b01,
    ISBC_DMA_BOTH = 2'b10
  } isbc_dma_t;

endpackage : isbc_pkg

//--- logic/isbc_bank_mem.sv
// Purpose: Byte store for the plain read/write registers of all banks
// Assumes: One write and one read per cycle
// Notes: Read data is registered

`timescale 1ns/100ps
`default_nettype none

module isbc_bank_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : isbc_bank_mem

`default_nettype wire

//--- logic/isbc_ctrl.sv
// Purpose: Bank-switched control window of the IR-capable serial port
// Assumes: Host strobes are synchronous to sys_clk; one access per cycle
// Notes: Datapath status arrives as inputs; datapath controls leave as outputs
//
// Contract
// - Four modes: UART, vendor IR, serial infrared, consumer remote IR.
// - UART runs as 16450, 16550 or extended level.
// - Reset or 16550-style init falls back to 16550 level.
// - Two DMA channels; either alone or both may be used.
// - Eight banks of eight byte registers.
// - Banks share offsets 0-7; active bank picks the register.
// - Bank selector sits at offset 3 in every bank.
// - Bank selector resets to bank 0.
// - Banks 0-3 serve UART and IR; bank 0 global, bank 1 legacy.
// - Banks 4-7 hold IR setup only; no UART effect.
// - Bank 2 holds alternate divisor and extended control/status.
// - Bank 3 holds revision id and read-only shadows.
// - Bank 7 holds remote IR and transceiver setup.
// - Read-type offsets read one register, writes reach another.
// - Write-one-clear bits clear on 1, ignore 0.

`timescale 1ns/100ps
`default_nettype none

module isbc_ctrl
  import isbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [isbc_pkg::ISBC_AW-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] event_id,
  input wire logic [7:0] lsr_set,
  input wire logic [7:0] ascr_set,
  input wire logic [7:0] modem_status,
  input wire logic [4:0] tx_level,
  input wire logic [4:0] rx_level,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic [7:0] fifo_ctrl,
  output logic [7:0] link_ctrl,
  output logic [15:0] baud_div,
  output logic [1:0] uart_level,
  output logic [2:0] op_mode,
  output logic [1:0] dma_use,
  output logic [7:0] bank_sel
);

  // ********************************************************
  // Bank decode
  // ********************************************************
  logic [7:0] bank_sel_reg;
  logic [7:0] lcr_reg;
  logic [7:0] fcr_reg;
  logic [7:0] lsr_reg;
  logic [7:0] ascr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] excr1_reg;
  logic [7:0] excr2_reg;
  isbc_level_t level_reg;
  logic [2:0] bank;
  logic [2:0] rd_off_reg;
  logic [2:0] rd_bank_reg;
  logic rd_pend_reg;
  logic [7:0] mem_rdata;
  logic wr_sel;
  logic wr_plain;

  function automatic logic [2:0] sel_to_bank(input logic [7:0] sel);
    if (!sel[ISBC_BKSE_BIT]) return ISBC_BANK0;
    unique case (sel)
      ISBC_SEL_B2: return ISBC_BANK2;
      ISBC_SEL_B3: return ISBC_BANK3;
      ISBC_SEL_B4: return ISBC_BANK4;
      ISBC_SEL_B5: return ISBC_BANK5;
      ISBC_SEL_B6: return ISBC_BANK6;
      ISBC_SEL_B7: return ISBC_BANK7;
      default: return ISBC_BANK1;
    endcase
  endfunction : sel_to_bank

  // Offset 3 is always the selector; lower selector values are the LCR
  function automatic logic is_sel(input logic [2:0] off);
    return off == ISBC_OFF_BANKSEL;
  endfunction : is_sel

  assign bank = sel_to_bank(bank_sel_reg);
  assign wr_sel = host_wr && is_sel(host_addr);

  // ********************************************************
  // Bank selector and link control
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bank_sel_reg <= ISBC_BANKSEL_RST;
      lcr_reg <= ISBC_ZERO;
    end else if (clk_en && wr_sel) begin
      // Settles in one edge, so the next access sees the new bank
      bank_sel_reg <= host_wdata;
      if (!host_wdata[ISBC_BKSE_BIT]) begin
        lcr_reg <= host_wdata;
      end
    end
  end

  // ********************************************************
  // Mode, level and DMA controls
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mcr_reg <= ISBC_ZERO;
      excr1_reg <= ISBC_ZERO;
      excr2_reg <= ISBC_ZERO;
      fcr_reg <= ISBC_ZERO;
      level_reg <= ISBC_LVL_16550;
    end else if (clk_en && host_wr) begin
      if (bank == ISBC_BANK0 && host_addr == ISBC_OFF_MCR) begin
        mcr_reg <= host_wdata;
      end
      if (bank == ISBC_BANK0 && host_addr == ISBC_OFF_EVFIFO) begin
        fcr_reg <= host_wdata;
        // Legacy drivers write the FIFO control first; leave extended mode
        if (level_reg == ISBC_LVL_EXT || host_wdata[ISBC_FIFO_EN_BIT]) begin
          level_reg <= ISBC_LVL_16550;
        end else begin
          // FIFOs off outside extended level act as the plain 16450
          level_reg <= ISBC_LVL_16450;
        end
      end
      if (bank == ISBC_BANK2 && host_addr == ISBC_OFF_EVFIFO) begin
        excr1_reg <= host_wdata;
        level_reg <= host_wdata[ISBC_EXT_SL_BIT] ? ISBC_LVL_EXT
                                                 : ISBC_LVL_16550;
      end
      if (bank == ISBC_BANK2 && host_addr == ISBC_OFF_MCR) begin
        excr2_reg <= host_wdata;
      end
    end
  end

  // ********************************************************
  // Write-one-clear status
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lsr_reg <= ISBC_LSR_RST;
      ascr_reg <= ISBC_ZERO;
    end else if (clk_en) begin
      // New events win over a clear in the same cycle
      if (host_wr && bank == ISBC_BANK0 && host_addr == ISBC_OFF_LSR) begin
        lsr_reg <= (lsr_reg & ~(host_wdata & ISBC_LSR_W1C_MASK))
                   | lsr_set;
      end else begin
        lsr_reg <= lsr_reg | lsr_set;
      end
      if (host_wr && bank == ISBC_BANK0 && host_addr == ISBC_OFF_SPR &&
          level_reg == ISBC_LVL_EXT) begin
        ascr_reg <= (ascr_reg & ~(host_wdata & ISBC_ASCR_W1C_MASK))
                    | ascr_set;
      end else begin
        ascr_reg <= ascr_reg | ascr_set;
      end
    end
  end

  // ********************************************************
  // Plain byte registers in the bank store
  // ********************************************************
  assign wr_plain = host_wr && !is_sel(host_addr) &&
                    !(bank == ISBC_BANK0 && host_addr != ISBC_OFF_IER &&
                      !(host_addr == ISBC_OFF_SPR &&
                        level_reg != ISBC_LVL_EXT));

  isbc_bank_mem #(
    .DEPTH(ISBC_NBANK * 8),
    .AW(6)
  ) u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(wr_plain),
    .wr_addr({bank, host_addr}),
    .wr_data(host_wdata),
    .rd_addr({bank, host_addr}),
    .rd_data(mem_rdata)
  );

  // ********************************************************
  // Read path
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_pend_reg <= 1'b0;
      rd_off_reg <= ISBC_OFF_RXTX;
      rd_bank_reg <= ISBC_BANK0;
    end else if (clk_en) begin
      rd_pend_reg <= host_rd;
      rd_off_reg <= host_addr;
      rd_bank_reg <= bank;
    end
  end

  // Read mux looks at the registered bank, so a read after a select is exact
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      host_rdata <= ISBC_ZERO;
      host_rvalid <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= rd_pend_reg;
      if (rd_pend_reg) begin
        if (is_sel(rd_off_reg)) begin
          host_rdata <= bank_sel_reg;
        end else if (rd_bank_reg == ISBC_BANK0) begin
          unique case (rd_off_reg)
            ISBC_OFF_RXTX: host_rdata <= rx_data;
            ISBC_OFF_EVFIFO: host_rdata <= event_id;
            ISBC_OFF_MCR: host_rdata <= mcr_reg;
            ISBC_OFF_LSR: host_rdata <= lsr_reg;
            ISBC_OFF_MSR: host_rdata <= modem_status;
            ISBC_OFF_SPR: host_rdata <= (level_reg == ISBC_LVL_EXT) ?
                                        ascr_reg : mem_rdata;
            default: host_rdata <= mem_rdata;
          endcase
        end else if (rd_bank_reg == ISBC_BANK2) begin
          unique case (rd_off_reg)
            ISBC_OFF_EVFIFO: host_rdata <= excr1_reg;
            ISBC_OFF_MCR: host_rdata <= excr2_reg;
            ISBC_OFF_MSR: host_rdata <= {3'h0, tx_level};
            ISBC_OFF_SPR: host_rdata <= {3'h0, rx_level};
            default: host_rdata <= mem_rdata;
          endcase
        end else if (rd_bank_reg == ISBC_BANK3) begin
          unique case (rd_off_reg)
            ISBC_OFF_RXTX: host_rdata <= {ISBC_MODULE_ID, ISBC_REV_ID};
            ISBC_OFF_IER: host_rdata <= lcr_reg;
            ISBC_OFF_EVFIFO: host_rdata <= fcr_reg;
            default: host_rdata <= ISBC_ZERO;
          endcase
        end else begin
          // Banks 1, 4-7 are plain storage; IR only for 4-7
          host_rdata <= mem_rdata;
        end
      end
    end
  end

  // ********************************************************
  // Outputs toward the datapath
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_data <= ISBC_ZERO;
      tx_load <= 1'b0;
    end else if (clk_en) begin
      tx_load <= host_wr && bank == ISBC_BANK0 &&
                 host_addr == ISBC_OFF_RXTX;
      if (host_wr && bank == ISBC_BANK0 && host_addr == ISBC_OFF_RXTX) begin
        tx_data <= host_wdata;
      end
    end
  end

  // Divisor shadowed in flops from writes to banks 1 and 2 low/high bytes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      baud_div <= 16'h0000;
    end else if (clk_en && host_wr &&
                 (bank == ISBC_BANK1 || bank == ISBC_BANK2)) begin
      if (host_addr == ISBC_OFF_RXTX) begin
        baud_div[7:0] <= host_wdata;
      end else if (host_addr == ISBC_OFF_IER) begin
        baud_div[15:8] <= host_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fifo_ctrl <= ISBC_ZERO;
      link_ctrl <= ISBC_ZERO;
      uart_level <= ISBC_LVL_16550;
      op_mode <= ISBC_MODE_UART;
      dma_use <= ISBC_DMA_NONE;
      bank_sel <= ISBC_BANKSEL_RST;
    end else if (clk_en) begin
      fifo_ctrl <= fcr_reg;
      link_ctrl <= lcr_reg;
      uart_level <= level_reg;
      bank_sel <= bank_sel_reg;
      // Non-UART modes only in extended level; others force UART
      if (level_reg == ISBC_LVL_EXT) begin
        op_mode <= mcr_reg[ISBC_MDSL_LSB +: 3];
      end else begin
        op_mode <= ISBC_MODE_UART;
      end
      // IR is half duplex: never both channels in IR modes
      if (!mcr_reg[ISBC_DMA_EN_BIT] || level_reg != ISBC_LVL_EXT) begin
        dma_use <= ISBC_DMA_NONE;
      end else if (mcr_reg[ISBC_MDSL_LSB +: 3] != ISBC_MODE_UART ||
                   !excr2_reg[ISBC_LOCK_BIT]) begin
        dma_use <= ISBC_DMA_ONE;
      end else begin
        dma_use <= ISBC_DMA_BOTH;
      end
    end
  end

endmodule : isbc_ctrl

`default_nettype wire

//--- verification/isbc_ctrl_properties.sv
// Purpose: Concurrent checks on the banked control window
// Assumes: Bound to isbc_ctrl; a single clock domain
// Notes: Watches design ports only, inputs and outputs; no internal signals
`timescale 1ns/100ps
`default_nettype none

module isbc_ctrl_properties
  import isbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [isbc_pkg::ISBC_AW-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rvalid,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  input wire logic [7:0] link_ctrl,
  input wire logic [15:0] baud_div,
  input wire logic [1:0] uart_level,
  input wire logic [2:0] op_mode,
  input wire logic [1:0] dma_use,
  input wire logic [7:0] bank_sel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic wt = host_wr && clk_en;
  wire logic b2 = bank_sel == ISBC_SEL_B2;

  property p_rd_ans;
    host_rd && clk_en ##1 clk_en |=> host_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered in two cycles");
  property p_sel;
    wt && host_addr == ISBC_OFF_BANKSEL ##1 clk_en
      |=> bank_sel == $past(host_wdata, 2);
  endproperty
  a_sel: assert property (p_sel)
    else $error("selector write not applied");
  property p_lcr;
    wt && host_addr == ISBC_OFF_BANKSEL && !host_wdata[7] ##1 clk_en
      |=> link_ctrl == $past(host_wdata, 2);
  endproperty
  a_lcr: assert property (p_lcr)
    else $error("link control not written");
  property p_tx;
    wt && !bank_sel[7] && host_addr == ISBC_OFF_RXTX
      && !$past(wt && host_addr == ISBC_OFF_BANKSEL)
      |=> tx_load && tx_data == $past(host_wdata);
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit byte not loaded");
  property p_rst;
    $rose(reset_n) |-> bank_sel == ISBC_BANKSEL_RST
      && uart_level == ISBC_LVL_16550;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  property p_ext;
    wt && b2 && host_addr == ISBC_OFF_EVFIFO && host_wdata[0]
      && !$past(wt && host_addr == ISBC_OFF_BANKSEL) ##1 clk_en
      |=> uart_level == ISBC_LVL_EXT;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended level not entered");
  property p_fall;
    wt && !bank_sel[7] && host_addr == ISBC_OFF_EVFIFO
      && uart_level == ISBC_LVL_EXT
      && !$past(wt && (host_addr == ISBC_OFF_BANKSEL ||
                       host_addr == ISBC_OFF_EVFIFO)) ##1 clk_en
      |=> uart_level == ISBC_LVL_16550;
  endproperty
  a_fall: assert property (p_fall)
    else $error("no fallback to 16550 level");
  property p_baud;
    wt && b2 && host_addr == ISBC_OFF_IER
      && !$past(wt && host_addr == ISBC_OFF_BANKSEL)
      |=> baud_div[15:8] == $past(host_wdata);
  endproperty
  a_baud: assert property (p_baud)
    else $error("divisor high byte not written");
  property p_mode;
    uart_level != ISBC_LVL_EXT |-> op_mode == ISBC_MODE_UART;
  endproperty
  a_mode: assert property (p_mode)
    else $error("infrared mode outside extended level");
  property p_dma;
    op_mode != ISBC_MODE_UART |-> dma_use != ISBC_DMA_BOTH;
  endproperty
  a_dma: assert property (p_dma)
    else $error("two channels in infrared mode");
endmodule : isbc_ctrl_properties

bind isbc_ctrl isbc_ctrl_properties isbc_ctrl_properties_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rvalid(host_rvalid),
  .tx_data(tx_data), .tx_load(tx_load), .link_ctrl(link_ctrl),
  .baud_div(baud_div), .uart_level(uart_level), .op_mode(op_mode),
  .dma_use(dma_use), .bank_sel(bank_sel)
);
`default_nettype wire

//--- verification/isbc_far_model.sv
// Purpose: Loopback modem on the far side of the port
// Assumes: Loads arrive as one-cycle pulses
// Notes: Echo is inverted so a read cannot pass for the sent byte
`timescale 1ns/100ps
`default_nettype none

module isbc_far_model (
  input wire logic sys_clk,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  output logic [7:0] rx_data,
  output logic [7:0] event_id,
  output logic [7:0] modem_status,
  output logic [4:0] tx_level,
  output logic [4:0] rx_level
);
  logic [4:0] cnt = 5'h00;
  initial rx_data = 8'h00;
  always @(negedge sys_clk) begin
    if (tx_load === 1'b1) begin
      rx_data <= ~tx_data;
      cnt <= cnt + 5'h01;
    end
  end
  assign tx_level = cnt;
  assign rx_level = ~cnt;
  assign event_id = {3'h0, cnt};
  assign modem_status = {cnt, 3'h5};
endmodule : isbc_far_model
`default_nettype wire

//--- verification/isbc_ctrl_tb.sv
// Purpose: Self-checking bench for the banked control window
// Assumes: Strobes driven on the falling edge
// Notes: Random data from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", n, e, s); end end

module isbc_ctrl_tb;
  import isbc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] lsr_set = 8'h00;
  logic [7:0] ascr_set = 8'h00;
  logic [7:0] rx_data, event_id, modem_status, host_rdata, tx_data;
  logic [7:0] fifo_ctrl, link_ctrl, bank_sel;
  logic [4:0] tx_level, rx_level;
  logic [15:0] baud_div;
  logic [1:0] uart_level, dma_use;
  logic [2:0] op_mode;
  logic host_rvalid, tx_load;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  isbc_ctrl isbc_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .rx_data(rx_data),
    .event_id(event_id), .lsr_set(lsr_set), .ascr_set(ascr_set),
    .modem_status(modem_status), .tx_level(tx_level),
    .rx_level(rx_level), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .tx_data(tx_data), .tx_load(tx_load),
    .fifo_ctrl(fifo_ctrl), .link_ctrl(link_ctrl), .baud_div(baud_div),
    .uart_level(uart_level), .op_mode(op_mode), .dma_use(dma_use),
    .bank_sel(bank_sel));
  isbc_far_model isbc_far_model_inst (.sys_clk(sys_clk),
    .tx_data(tx_data), .tx_load(tx_load), .rx_data(rx_data),
    .event_id(event_id), .modem_status(modem_status),
    .tx_level(tx_level), .rx_level(rx_level));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Write strobe stays up so writes can run back to back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_rd = 1'b0;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge sys_clk);
  endtask : wr

  task automatic nop();
    host_wr = 1'b0;
    host_rd = 1'b0;
    @(negedge sys_clk);
  endtask : nop

  task automatic rd(input logic [2:0] a, input logic [7:0] e, string n);
    int k;
    k = 0;
    host_wr = 1'b0;
    host_addr = a;
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
    while (host_rvalid !== 1'b1 && k < 4) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(n, e, host_rdata)
  endtask : rd

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    logic [7:0] d, h;
    logic [15:0] bd;
    logic [4:0] nld;
    logic [2:0] m;
    logic [7:0] sels [7] = '{8'h80, ISBC_SEL_B2, ISBC_SEL_B3,
      ISBC_SEL_B4, ISBC_SEL_B5, ISBC_SEL_B6, ISBC_SEL_B7};
    nld = 5'h00;
    d = 8'($urandom(97));
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    `CHK("level", ISBC_LVL_16550, uart_level)
    `CHK("mode", ISBC_MODE_UART, op_mode)
    rd(ISBC_OFF_BANKSEL, ISBC_BANKSEL_RST, "sel");
    rd(ISBC_OFF_LSR, ISBC_LSR_RST, "lsr");
    lsr_set = ISBC_LSR_W1C_MASK;
    @(negedge sys_clk);
    lsr_set = 8'h00;
    rd(ISBC_OFF_LSR, 8'h7e, "lsr");
    wr(ISBC_OFF_LSR, 8'h76);
    wr(ISBC_OFF_LSR, 8'h60);
    rd(ISBC_OFF_LSR, 8'h68, "lsr");
    wr(ISBC_OFF_EVFIFO, 8'h00);
    nop();
    `CHK("level", ISBC_LVL_16450, uart_level)
    wr(ISBC_OFF_EVFIFO, 8'h01);
    nop();
    `CHK("level", ISBC_LVL_16550, uart_level)
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(ISBC_OFF_RXTX, d);
      `CHK("txd", d, tx_data)
      `CHK("load", 1'b1, tx_load)
      nop();
      nld++;
      rd(ISBC_OFF_RXTX, ~d, "rxd");
    end
    for (int j = 0; j < 7; j++) begin
      wr(ISBC_OFF_BANKSEL, sels[j]);
      rd(ISBC_OFF_BANKSEL, sels[j], "sel");
    end
    for (int j = 0; j < 2; j++) begin
      d = 8'($urandom);
      h = 8'($urandom);
      wr(ISBC_OFF_BANKSEL, j == 0 ? ISBC_SEL_B2 : 8'h80);
      wr(ISBC_OFF_RXTX, d);
      wr(ISBC_OFF_IER, h);
      nop();
      `CHK("baud", {h, d}, baud_div)
      bd = {h, d};
      rd(ISBC_OFF_RXTX, d, "dl");
      rd(ISBC_OFF_IER, h, "dh");
    end
    wr(ISBC_OFF_BANKSEL, ISBC_SEL_B2);
    rd(ISBC_OFF_MSR, {3'h0, nld}, "txlv");
    wr(ISBC_OFF_EVFIFO, 8'h01);
    wr(ISBC_OFF_MCR, 8'h80);
    nop();
    `CHK("level", ISBC_LVL_EXT, uart_level)
    wr(ISBC_OFF_BANKSEL, 8'h03);
    for (int j = 0; j < 4; j++) begin
      m = 3'(j);
      wr(ISBC_OFF_MCR, {m, 5'h04});
      nop();
      `CHK("mode", m, op_mode)
      `CHK("dma", m == 0 ? ISBC_DMA_BOTH : ISBC_DMA_ONE, dma_use)
    end
    ascr_set = ISBC_ASCR_W1C_MASK;
    nop();
    ascr_set = 8'h00;
    wr(ISBC_OFF_SPR, 8'h0c);
    rd(ISBC_OFF_SPR, 8'h51, "ascr");
    wr(ISBC_OFF_EVFIFO, 8'hc1);
    nop();
    `CHK("level", ISBC_LVL_16550, uart_level)
    `CHK("mode", ISBC_MODE_UART, op_mode)
    `CHK("fcr", 8'hc1, fifo_ctrl)
    wr(ISBC_OFF_BANKSEL, ISBC_SEL_B3);
    rd(ISBC_OFF_RXTX, {ISBC_MODULE_ID, ISBC_REV_ID}, "id");
    wr(ISBC_OFF_EVFIFO, 8'h5a);
    rd(ISBC_OFF_EVFIFO, 8'hc1, "shfcr");
    rd(ISBC_OFF_MCR, ISBC_ZERO, "rsv");
    wr(ISBC_OFF_BANKSEL, ISBC_SEL_B7);
    d = 8'($urandom);
    wr(ISBC_OFF_RXTX, d);
    wr(ISBC_OFF_MCR, 8'hff);
    rd(ISBC_OFF_RXTX, d, "b7");
    `CHK("level", ISBC_LVL_16550, uart_level)
    `CHK("baud", bd, baud_div)
    clk_en = 1'b0;
    wr(ISBC_OFF_BANKSEL, ISBC_SEL_B4);
    nop();
    clk_en = 1'b1;
    `CHK("sel", ISBC_SEL_B7, bank_sel)
    reset_n = 1'b0;
    @(negedge sys_clk);
    reset_n = 1'b1;
    `CHK("sel", ISBC_BANKSEL_RST, bank_sel)
    `CHK("level", ISBC_LVL_16550, uart_level)
    conclude();
  end
endmodule : isbc_ctrl_tb
`default_nettype wire
